// [rtl/io_ports_regs.svh]
// register offsets, field positions and reset values of the port block
`ifndef IO_PORTS_REGS_SVH
`define IO_PORTS_REGS_SVH

`define ADDR_OPTION        4'h0
`define ADDR_IN_LEVEL      4'h1
`define ADDR_IN_FLAGS      4'h2
`define ADDR_IN_ENABLE     4'h3
`define ADDR_B_DATA        4'h4
`define ADDR_B_DIR         4'h5
`define ADDR_C_DATA        4'h6
`define ADDR_C_FLAGS       4'h7
`define ADDR_C_ENABLE      4'h8
`define ADDR_PORTS_CTRL    4'h9
`define ADDR_SLEEP_CTRL    4'hA

`define OPT_WATCHDOG_DIS   0
`define OPT_IN_DEB_BYPASS  1
`define OPT_C_DEB_BYPASS   2
`define OPT_RISING_EDGE    3

`define CTRL_COMBINE       0
`define CTRL_C_DIR         1

`define SLP_B_RELEASE      0
`define SLP_BUZZER_ON_B0   1

`define RESET_NIBBLE       4'h0
`define SLOW_TAP_HZ        128
`define FAST_TAP_HZ        1024

`endif

// [rtl/io_ports_pkg.sv]
// types shared by the port block
package io_ports_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic [3:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic [3:0] din;
    logic [3:0] dout;
    logic [3:0] oe_n;
  } pin_group_t;

  typedef enum logic [1:0] {
    DEB_IDLE   = 2'b00,
    DEB_SEEN1  = 2'b01,
    DEB_ACCEPT = 2'b10
  } deb_state_t;

endpackage : io_ports_pkg

// [rtl/io_ports.sv]
// port block: input port, bitwise i/o port, whole-port i/o port with edge interrupts
// Contract
// RULE_01: edge select bit picks falling or rising
// RULE_02: input port debounced unless bypass set
// RULE_03: third port debounced unless bypass set
// RULE_04: debounce needs two stable sample edges
// RULE_05: watchdog disable bit stops the watchdog
// RULE_06: debounced lines 0-2 feed test variables
// RULE_07: input line 3 feeds event counter
// RULE_08: input masks reset to zero
// RULE_09: reading input flags clears them and summary
// RULE_10: input level register returns pin levels
// RULE_11: second port per-bit direction bits
// RULE_12: second data reads pins, writes outputs
// RULE_13: second direction resets to inputs
// RULE_14: blocked option hides pins of outputs
// RULE_15: sleep release tri-states second outputs
// RULE_16: second line 0 can carry buzzer
// RULE_17: one bit sets third port direction
// RULE_18: third port has masked edge interrupts
// RULE_19: third direction and mask reset zero
// RULE_20: combine bit ANDs port requests
// RULE_21: combine bit0, third direction bit1
// RULE_22: flags set only when masked in
// RULE_23: pins synchronised before edge compare
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
`include "io_ports_regs.svh"

module io_ports #(
  parameter int  WIDTH         = 4,
  parameter bit  INPUT_BLOCKED = 1'b0
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic                     clk_en,
  input  wire io_ports_pkg::reg_req_t   req,
  output      logic [3:0]               rdata,
  input  wire logic                     fast_tap,
  input  wire logic                     slow_tap,
  input  wire logic                     use_slow_tap,
  input  wire logic                     sleep,
  input  wire logic                     buzzer_tone,
  input  wire logic                     buzzer_en,
  input  wire logic [3:0]               in_pins,
  input  wire logic [3:0]               b_pins_in,
  output      logic [3:0]               b_pins_out,
  output      logic [3:0]               b_pins_oe_n,
  input  wire logic [3:0]               c_pins_in,
  output      logic [3:0]               c_pins_out,
  output      logic [3:0]               c_pins_oe_n,
  output      logic                     branch_test_var_one,
  output      logic                     branch_test_var_two,
  output      logic                     branch_test_var_three,
  output      logic                     event_count_in,
  output      logic                     watchdog_disable,
  output      logic                     central_irq_request,
  output      logic                     input_port_summary_flag,
  output      logic                     buzzer_on_b0
);
  import io_ports_pkg::*;

  if (WIDTH != 4) begin : g_width_check
    $error("port width must be 4");
  end

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic [3:0] in_s1_ff, in_s2_ff, b_s1_ff, b_s2_ff, c_s1_ff, c_s2_ff;
  logic [1:0] tap_s1_ff, tap_s2_ff, tap_prev_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      in_s1_ff <= `RESET_NIBBLE;
      in_s2_ff <= `RESET_NIBBLE;
    end else if (clk_en) begin
      in_s1_ff <= in_pins;                    // [RULE_23]
      in_s2_ff <= in_s1_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      b_s1_ff <= `RESET_NIBBLE;
      b_s2_ff <= `RESET_NIBBLE;
    end else if (clk_en) begin
      b_s1_ff <= b_pins_in;
      b_s2_ff <= b_s1_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      c_s1_ff <= `RESET_NIBBLE;
      c_s2_ff <= `RESET_NIBBLE;
    end else if (clk_en) begin
      c_s1_ff <= c_pins_in;                   // [RULE_23]
      c_s2_ff <= c_s1_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tap_s1_ff   <= 2'h0;
      tap_s2_ff   <= 2'h0;
      tap_prev_ff <= 2'h0;
    end else if (clk_en) begin
      tap_s1_ff   <= {slow_tap, fast_tap};
      tap_s2_ff   <= tap_s1_ff;
      tap_prev_ff <= tap_s2_ff;
    end
  end

  logic sample_tick;
  assign sample_tick = use_slow_tap ? (tap_s2_ff[1] & ~tap_prev_ff[1])
                                    : (tap_s2_ff[0] & ~tap_prev_ff[0]);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [3:0] option_ff, in_enable_ff, b_data_ff, b_dir_ff;
  logic [3:0] c_data_ff, c_enable_ff, sleep_ctrl_ff;
  logic [1:0] ports_ctrl_ff;

  function automatic logic wr_hit(input reg_req_t r, input logic [3:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction : wr_hit

  function automatic logic rd_hit(input reg_req_t r, input logic [3:0] a);
    rd_hit = r.rd && (r.addr == a);
  endfunction : rd_hit

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      option_ff <= `RESET_NIBBLE;
    end else if (clk_en && wr_hit(req, `ADDR_OPTION)) begin
      option_ff <= req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      in_enable_ff <= `RESET_NIBBLE;          // [RULE_08]
    end else if (clk_en && wr_hit(req, `ADDR_IN_ENABLE)) begin
      in_enable_ff <= req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      b_data_ff <= `RESET_NIBBLE;
    end else if (clk_en && wr_hit(req, `ADDR_B_DATA)) begin
      b_data_ff <= req.wdata;                 // [RULE_12]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      b_dir_ff <= `RESET_NIBBLE;              // [RULE_13]
    end else if (clk_en && wr_hit(req, `ADDR_B_DIR)) begin
      b_dir_ff <= req.wdata;                  // [RULE_11]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      c_data_ff <= `RESET_NIBBLE;
    end else if (clk_en && wr_hit(req, `ADDR_C_DATA)) begin
      c_data_ff <= req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      c_enable_ff <= `RESET_NIBBLE;           // [RULE_19]
    end else if (clk_en && wr_hit(req, `ADDR_C_ENABLE)) begin
      c_enable_ff <= req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ports_ctrl_ff <= 2'h0;                  // [RULE_19] [RULE_21]
    end else if (clk_en && wr_hit(req, `ADDR_PORTS_CTRL)) begin
      ports_ctrl_ff <= req.wdata[1:0];        // [RULE_21]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sleep_ctrl_ff <= `RESET_NIBBLE;
    end else if (clk_en && wr_hit(req, `ADDR_SLEEP_CTRL)) begin
      sleep_ctrl_ff <= req.wdata;
    end
  end

  assign watchdog_disable = option_ff[`OPT_WATCHDOG_DIS];   // [RULE_05]

  // ----------------------------------------------------------------
  // debouncers
  // ----------------------------------------------------------------
  logic [7:0] raw_all;
  assign raw_all = {c_s2_ff, in_s2_ff};
  logic [7:0] deb_level_ff;
  deb_state_t deb_state_ff [8];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      deb_level_ff <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        deb_state_ff[i] <= DEB_IDLE;
      end
    end else if (clk_en && sample_tick) begin
      for (int i = 0; i < 8; i++) begin
        case (deb_state_ff[i])           // [RULE_04]
          DEB_IDLE: begin
            if (raw_all[i] != deb_level_ff[i]) deb_state_ff[i] <= DEB_SEEN1;
          end
          DEB_SEEN1: begin
            if (raw_all[i] != deb_level_ff[i]) deb_state_ff[i] <= DEB_ACCEPT;
            else deb_state_ff[i] <= DEB_IDLE;
          end
          DEB_ACCEPT: begin
            deb_state_ff[i] <= DEB_IDLE;
          end
          default: deb_state_ff[i] <= DEB_IDLE;
        endcase
        if (deb_state_ff[i] == DEB_SEEN1 && raw_all[i] != deb_level_ff[i]) begin
          deb_level_ff[i] <= raw_all[i];
        end
      end
    end
  end

  logic [3:0] in_eff, c_eff;
  assign in_eff = option_ff[`OPT_IN_DEB_BYPASS] ? in_s2_ff : deb_level_ff[3:0];  // [RULE_02]
  assign c_eff  = option_ff[`OPT_C_DEB_BYPASS]  ? c_s2_ff  : deb_level_ff[7:4];  // [RULE_03]

  assign branch_test_var_one   = deb_level_ff[0];   // [RULE_06]
  assign branch_test_var_two   = deb_level_ff[1];   // [RULE_06]
  assign branch_test_var_three = deb_level_ff[2];   // [RULE_06]
  assign event_count_in        = in_eff[3];         // [RULE_07]

  // ----------------------------------------------------------------
  // edge detection and request flags
  // ----------------------------------------------------------------
  logic [3:0] in_prev_ff, c_prev_ff, in_flags_ff, c_flags_ff;

  function automatic logic [3:0] edges(input logic [3:0] cur, input logic [3:0] prev,
                                       input logic rising);
    edges = rising ? (cur & ~prev) : (~cur & prev);
  endfunction : edges

  logic [3:0] in_hit, c_hit;
  logic       c_is_input;
  assign c_is_input = ~ports_ctrl_ff[`CTRL_C_DIR];
  assign in_hit = edges(in_eff, in_prev_ff, option_ff[`OPT_RISING_EDGE]) & in_enable_ff;  // [RULE_01] [RULE_22]
  assign c_hit  = edges(c_eff, c_prev_ff, option_ff[`OPT_RISING_EDGE]) & c_enable_ff
                  & {4{c_is_input}};                                                       // [RULE_18]

  logic rd_in_flags, rd_c_flags;
  assign rd_in_flags = rd_hit(req, `ADDR_IN_FLAGS);
  assign rd_c_flags  = rd_hit(req, `ADDR_C_FLAGS);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      in_prev_ff  <= `RESET_NIBBLE;
      in_flags_ff <= `RESET_NIBBLE;           // [RULE_09]
    end else if (clk_en) begin
      in_prev_ff  <= in_eff;
      in_flags_ff <= (rd_in_flags ? `RESET_NIBBLE : in_flags_ff) | in_hit;   // [RULE_09] [RULE_22]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      c_prev_ff  <= `RESET_NIBBLE;
      c_flags_ff <= `RESET_NIBBLE;
    end else if (clk_en) begin
      c_prev_ff  <= c_eff;
      c_flags_ff <= (rd_c_flags ? `RESET_NIBBLE : c_flags_ff) | c_hit;       // [RULE_18]
    end
  end

  logic in_req, c_req;
  assign in_req = |in_flags_ff;                // [RULE_22]
  assign c_req  = |c_flags_ff;
  assign input_port_summary_flag = in_req;     // [RULE_09]
  assign central_irq_request = ports_ctrl_ff[`CTRL_COMBINE] ? (in_req & c_req)
                                                            : (in_req | c_req);  // [RULE_20]

  // ----------------------------------------------------------------
  // output pins
  // ----------------------------------------------------------------
  logic b0_buzzer;
  assign b0_buzzer    = buzzer_en & sleep_ctrl_ff[`SLP_BUZZER_ON_B0];
  assign buzzer_on_b0 = b0_buzzer;

  logic [3:0] b_drive;
  assign b_drive = (b_dir_ff | {3'h0, b0_buzzer})
                   & ~{4{sleep & sleep_ctrl_ff[`SLP_B_RELEASE]}};          // [RULE_11] [RULE_15]
  assign b_pins_oe_n = ~b_drive;
  assign b_pins_out  = {b_data_ff[3:1], b0_buzzer ? buzzer_tone : b_data_ff[0]};  // [RULE_16]
  assign c_pins_oe_n = {4{c_is_input}};                                    // [RULE_17]
  assign c_pins_out  = c_data_ff;                                          // [RULE_17]

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  function automatic logic [3:0] pin_view(input logic [3:0] pins, input logic [3:0] outs,
                                          input logic [3:0] dir);
    pin_view = INPUT_BLOCKED ? ((pins & ~dir) | (outs & dir)) : pins;      // [RULE_14]
  endfunction : pin_view

  logic [3:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 4'h0;
    if (req.rd) begin
      if (req.addr == `ADDR_OPTION) nxt_rdata = option_ff;
      else if (req.addr == `ADDR_IN_LEVEL) nxt_rdata = in_s2_ff;           // [RULE_10]
      else if (req.addr == `ADDR_IN_FLAGS) nxt_rdata = in_flags_ff;
      else if (req.addr == `ADDR_IN_ENABLE) nxt_rdata = in_enable_ff;
      else if (req.addr == `ADDR_B_DATA) nxt_rdata = pin_view(b_s2_ff, b_data_ff, b_dir_ff);  // [RULE_12]
      else if (req.addr == `ADDR_B_DIR) nxt_rdata = b_dir_ff;
      else if (req.addr == `ADDR_C_DATA) nxt_rdata = pin_view(c_s2_ff, c_data_ff, {4{~c_is_input}});
      else if (req.addr == `ADDR_C_FLAGS) nxt_rdata = c_flags_ff;
      else if (req.addr == `ADDR_C_ENABLE) nxt_rdata = c_enable_ff;
      else if (req.addr == `ADDR_PORTS_CTRL) nxt_rdata = {2'h0, ports_ctrl_ff};
      else if (req.addr == `ADDR_SLEEP_CTRL) nxt_rdata = sleep_ctrl_ff;
      else nxt_rdata = 4'h0;
    end
  end

  logic [3:0] rdata_ff;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_ff <= 4'h0;
    end else if (clk_en) begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign rdata = rdata_ff;

endmodule : io_ports

// [tb/io_ports_properties.sv]
// concurrent checks on the port block ports
`timescale 1ns/1ns
`include "io_ports_regs.svh"
module io_ports_properties (
  input wire logic                   sys_clk,
  input wire logic                   rst,
  input wire io_ports_pkg::reg_req_t req,
  input wire logic [3:0]             rdata,
  input wire logic [3:0]             in_pins,
  input wire logic [3:0]             b_pins_out,
  input wire logic [3:0]             b_pins_oe_n,
  input wire logic [3:0]             c_pins_oe_n,
  input wire logic                   sleep,
  input wire logic                   buzzer_tone,
  input wire logic                   buzzer_on_b0,
  input wire logic                   input_port_summary_flag,
  input wire logic                   central_irq_request
);
  import io_ports_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // bus steps
  // ------------------------------------------------------------
  sequence s_rd(logic [3:0] a);
    req.rd && req.addr == a;
  endsequence
  sequence s_wr(logic [3:0] a);
    req.wr && req.addr == a;
  endsequence
  property p_rdata_idle;
    !$past(req.rd) |-> rdata == 4'h0;
  endproperty
  property p_unmapped;
    s_rd(4'hF) |=> rdata == 4'h0;
  endproperty
  property p_level;
    $stable(in_pins) [*3] ##0 s_rd(`ADDR_IN_LEVEL) |=> rdata == $past(in_pins);
  endproperty
  property p_rst_dir;
    $past(rst) |-> b_pins_oe_n == 4'hF && c_pins_oe_n == 4'hF;
  endproperty
  property p_rst_irq;
    $past(rst) |-> !input_port_summary_flag && !central_irq_request;
  endproperty
  property p_c_whole;
    c_pins_oe_n == 4'h0 || c_pins_oe_n == 4'hF;
  endproperty
  property p_c_dir;
    s_wr(`ADDR_PORTS_CTRL) |=> c_pins_oe_n == {4{~$past(req.wdata[1])}};
  endproperty
  property p_b_dir;
    s_wr(`ADDR_B_DIR) ##0 !sleep |=> b_pins_oe_n[3:1] == ~$past(req.wdata[3:1]);
  endproperty
  property p_buzzer;
    buzzer_on_b0 |-> b_pins_out[0] == buzzer_tone;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_level: assert property (p_level) else $error("level read wrong");
  a_rst_dir: assert property (p_rst_dir) else $error("ports not inputs after reset");
  a_rst_irq: assert property (p_rst_irq) else $error("request after reset");
  a_c_whole: assert property (p_c_whole) else $error("third port split");
  a_c_dir: assert property (p_c_dir) else $error("third direction wrong");
  a_b_dir: assert property (p_b_dir) else $error("second direction wrong");
  a_buzzer: assert property (p_buzzer) else $error("buzzer not on line 0");
endmodule : io_ports_properties

bind io_ports io_ports_properties i_io_ports_properties (.sys_clk, .rst, .req, .rdata, .in_pins, .b_pins_out,
  .b_pins_oe_n, .c_pins_oe_n, .sleep, .buzzer_tone, .buzzer_on_b0, .input_port_summary_flag,
  .central_irq_request);

// [tb/port_loads.sv]
// switches and loads on the second and third port pins
`timescale 1ns/1ns
module port_loads (
  input  wire logic [3:0] b_out,
  input  wire logic [3:0] b_oe_n,
  input  wire logic [3:0] b_sw,
  output      logic [3:0] b_in,
  input  wire logic [3:0] c_out,
  input  wire logic [3:0] c_oe_n,
  input  wire logic [3:0] c_sw,
  output      logic [3:0] c_in
);
  // released lines show the switch level
  assign b_in = (b_out & ~b_oe_n) | (b_sw & b_oe_n);
  assign c_in = (c_out & ~c_oe_n) | (c_sw & c_oe_n);
endmodule : port_loads

// [tb/io_ports_bench.sv]
// self-checking bench of the port block
`timescale 1ns/1ns
`include "io_ports_regs.svh"
module io_ports_bench;
  import io_ports_pkg::*;
  logic sys_clk = 0, rst = 1, fast_tap = 0, sleep = 0, buzzer_tone = 0, buzzer_en = 0;
  logic slow_tap = 0, use_slow_tap = 0, clk_en = 1;
  logic branch_test_var_one, branch_test_var_two, branch_test_var_three, event_count_in;
  logic watchdog_disable, central_irq_request, input_port_summary_flag, buzzer_on_b0;
  reg_req_t   req = '0;
  logic [3:0] rdata, b_pins_in, b_pins_out, b_pins_oe_n, c_pins_in, c_pins_out, c_pins_oe_n;
  logic [3:0] in_pins = 4'h0, b_sw = 4'h0, c_sw = 4'h0, v, d, m, o, nw;
  logic [3:0] rl[8] = '{4'h0, 4'h2, 4'h3, 4'h5, 4'h7, 4'h8, 4'h9, 4'hF};
  logic       r;
  logic [3:0] tap_view;
  assign tap_view = {event_count_in, branch_test_var_three, branch_test_var_two, branch_test_var_one};
  int         n_errors = 0, tests_run = 0, seed = 32'h589bf649;
  always #5 sys_clk = ~sys_clk;
  io_ports i_io_ports (.sys_clk, .rst, .clk_en, .req, .rdata, .fast_tap, .slow_tap,
    .use_slow_tap, .sleep, .buzzer_tone, .buzzer_en, .in_pins, .b_pins_in, .b_pins_out, .b_pins_oe_n,
    .c_pins_in, .c_pins_out, .c_pins_oe_n, .branch_test_var_one, .branch_test_var_two, .branch_test_var_three,
    .event_count_in, .watchdog_disable, .central_irq_request, .input_port_summary_flag, .buzzer_on_b0);
  port_loads i_port_loads (.b_out(b_pins_out), .b_oe_n(b_pins_oe_n), .b_sw, .b_in(b_pins_in),
    .c_out(c_pins_out), .c_oe_n(c_pins_oe_n), .c_sw, .c_in(c_pins_in));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [3:0] edges(input logic [3:0] a, b, k, input logic rise);
    return (rise ? ~a & b : a & ~b) & k;
  endfunction : edges
  function automatic logic [3:0] b_read(input logic [3:0] dt, dir, sw);
    return (dt & dir) | (sw & ~dir);
  endfunction : b_read
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] a, dt);
    @(posedge sys_clk) req <= '{a, dt, 1'b1, 1'b0};
    @(posedge sys_clk) req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [3:0] q);
    @(posedge sys_clk) req <= '{a, 4'h0, 1'b0, 1'b1};
    @(posedge sys_clk) req.rd <= 1'b0;
    #1 q = rdata;
  endtask : rd
  task automatic chk(input string nm, input logic [3:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic rchk(input string nm, input logic [3:0] a, e);
    logic [3:0] q;
    rd(a, q);
    chk(nm, e, q);
  endtask : rchk
  task automatic tick(input int n, input logic s);
    repeat (2 * n) begin
      @(posedge sys_clk);
      if (s) slow_tap <= ~slow_tap;
      else fast_tap <= ~fast_tap;
      cyc(4);
    end
  endtask : tick
  task automatic report_and_stop;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  initial begin
    #400000;
    n_errors++;
    report_and_stop;
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rl[i]) rchk("reset", rl[i], 4'h0);
    wr(`ADDR_OPTION, 4'h9);
    cyc(2);
    chk("wd", 4'h1, watchdog_disable);
    wr(`ADDR_IN_ENABLE, 4'hF);
    @(posedge sys_clk) in_pins <= 4'hF;
    cyc(8);
    rchk("deb_wait", `ADDR_IN_FLAGS, 4'h0);
    tick(1, 1'b0);
    chk("deb_one", 4'h0, tap_view);
    tick(1, 1'b0);
    chk("taps", 4'hF, tap_view);
    rchk("deb_flag", `ADDR_IN_FLAGS, 4'hF);
    rchk("clear", `ADDR_IN_FLAGS, 4'h0);
    chk("sum", 4'h0, input_port_summary_flag);
    repeat (6) begin
      {o, r, m, nw} = 13'($random(seed));
      wr(`ADDR_OPTION, {r, 3'h7});
      wr(`ADDR_IN_ENABLE, m);
      rd(`ADDR_IN_FLAGS, v);
      o = in_pins;
      @(posedge sys_clk) in_pins <= nw;
      cyc(6);
      rchk("flags", `ADDR_IN_FLAGS, edges(o, nw, m, r));
      rchk("level", `ADDR_IN_LEVEL, nw);
    end
    wr(`ADDR_OPTION, 4'hF);
    wr(`ADDR_C_ENABLE, 4'hF);
    wr(`ADDR_IN_ENABLE, 4'hF);
    @(posedge sys_clk) in_pins <= 4'h0;
    c_sw <= 4'hF;
    cyc(6);
    rd(`ADDR_IN_FLAGS, v);
    cyc(2);
    chk("or", 4'h1, central_irq_request);
    wr(`ADDR_PORTS_CTRL, 4'h1);
    cyc(2);
    chk("and", 4'h0, central_irq_request);
    @(posedge sys_clk) in_pins <= 4'hF;
    cyc(6);
    chk("both", 4'h1, central_irq_request);
    rchk("c_flags", `ADDR_C_FLAGS, 4'hF);
    cyc(2);
    chk("and_clr", 4'h0, central_irq_request);
    wr(`ADDR_OPTION, 4'h8);
    @(posedge sys_clk) use_slow_tap <= 1'b1;
    tick(2, 1'b0);
    rchk("c_fast", `ADDR_C_FLAGS, 4'h0);
    tick(1, 1'b1);
    rchk("c_one", `ADDR_C_FLAGS, 4'h0);
    tick(1, 1'b1);
    rchk("c_deb", `ADDR_C_FLAGS, 4'hF);
    wr(`ADDR_C_DATA, 4'hA);
    wr(`ADDR_PORTS_CTRL, 4'h2);
    cyc(2);
    chk("c_oe", 4'h0, c_pins_oe_n);
    chk("c_out", 4'hA, c_pins_out);
    repeat (6) begin
      {d, m, o} = 12'($random(seed));
      @(posedge sys_clk) b_sw <= o;
      wr(`ADDR_B_DATA, d);
      wr(`ADDR_B_DIR, m);
      cyc(3);
      chk("b_oe", ~m, b_pins_oe_n);
      chk("b_out", d & m, b_pins_out & m);
      rchk("b_rd", `ADDR_B_DATA, b_read(d, m, o));
    end
    @(posedge sys_clk) clk_en <= 1'b0;
    wr(`ADDR_IN_ENABLE, 4'h0);
    @(posedge sys_clk) clk_en <= 1'b1;
    rchk("frozen", `ADDR_IN_ENABLE, 4'hF);
    wr(`ADDR_B_DIR, 4'hF);
    wr(`ADDR_SLEEP_CTRL, 4'h1);
    @(posedge sys_clk) sleep <= 1'b1;
    cyc(2);
    chk("slp_rel", 4'hF, b_pins_oe_n);
    wr(`ADDR_SLEEP_CTRL, 4'h0);
    cyc(2);
    chk("slp_keep", 4'h0, b_pins_oe_n);
    @(posedge sys_clk) sleep <= 1'b0;
    wr(`ADDR_SLEEP_CTRL, 4'h2);
    @(posedge sys_clk) buzzer_en <= 1'b1;
    repeat (4) @(posedge sys_clk) buzzer_tone <= ~buzzer_tone;
    cyc(1);
    chk("bz", 4'h1, buzzer_on_b0);
    report_and_stop;
  end
endmodule : io_ports_bench
